// >>> lcm_pkg.sv
/*
  Constants and types shared by the level-one cache maintenance control
  block: register offsets, field positions, reset values, flush walker
  states and cache operation codes.
  Assumes a 32-bit APB register bus with 12-bit byte addresses.
*/
package lcm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] LCM_CFG_OFS = 12'h000;
  localparam logic [11:0] LCM_MSS_OFS = 12'h004;
  localparam logic [11:0] LCM_STAT_OFS = 12'h008;

  // ----------------------------------------------------------------
  // Field positions of hardware_impl_config
  // ----------------------------------------------------------------
  localparam int LCM_ICE_BIT = 0;
  localparam int LCM_ICACHE_LOCK_BIT_BIT = 1;
  localparam int LCM_ICACHE_FLASH_INV_BIT_BIT = 2;
  localparam int LCM_DCE_BIT = 3;
  localparam int LCM_DCACHE_FLASH_INV_BIT_BIT = 4;
  localparam int LCM_TDIS_BIT = 5;
  localparam int LCM_DLOCK_BIT = 6;

  // ----------------------------------------------------------------
  // Field positions of memsub_config_reg and status
  // ----------------------------------------------------------------
  localparam int LCM_HWF_BIT = 0;
  localparam int LCM_L2_DATA_ONLY_MODE_BIT = 1;
  localparam int LCM_BUSY_BIT = 0;
  localparam int LCM_IDX_LSB = 8;
  localparam int LCM_WAY_LSB = 24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic LCM_CTL_RST = 1'b0;
  localparam logic [31:0] LCM_RD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LCM_FL_IDLE = 2'b00,
    LCM_FL_CHECK = 2'b01,
    LCM_FL_WB = 2'b11
  } lcm_flush_state_type;

  typedef enum logic [2:0] {
    LCM_OP_DSTORE = 3'h0,
    LCM_OP_DFLUSH = 3'h1,
    LCM_OP_DINV = 3'h2,
    LCM_OP_IINV = 3'h3,
    LCM_OP_TOUCH = 3'h4
  } lcm_cop_type;

endpackage : lcm_pkg

// >>> lcm_walk.sv
/*
  Index and way walker for the data cache hardware flush.
  Assumes start is a one-cycle pulse and step a per-cycle enable from the flush sequencer.
*/
module lcm_walk
  import lcm_pkg::*;
#(
  parameter int SETS = 128,
  parameter int WAYS = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic step,
  output logic [$clog2(SETS)-1:0] idx,
  output logic [$clog2(WAYS)-1:0] way,
  output logic last
);

  // Geometry the walker can count through without a wrap check
  if (SETS < 2 || (SETS & (SETS - 1)) != 0)
  begin : g_sets_chk
    $error("SETS must be a power of two");
  end
  if (WAYS < 2 || (WAYS & (WAYS - 1)) != 0)
  begin : g_ways_chk
    $error("WAYS must be a power of two");
  end

  // ----------------------------------------------------------------
  // Position
  // ----------------------------------------------------------------
  // Ascending index within a way, then next way from index zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx <= '0;
      way <= '0;
    end
    else if (start)
    begin
      idx <= '0;
      way <= '0;
    end
    else if (step)
    begin
      idx <= idx + 1'b1;
      if (&idx)
        way <= way + 1'b1;
    end
  end

  // Final slot of the final way
  assign last = (&idx) & (&way);

endmodule : lcm_walk

// >>> lcm_touch.sv
/*
  Decision logic for the data-block touch (prefetch) operation.
  Assumes the request carries translation, permission and lookup results
  as flags that are valid in the cycle of touch_vld.
*/
module lcm_touch
  import lcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic touch_vld,
  input wire logic seg_t,
  input wire logic touch_dis,
  input wire logic xlat_ok,
  input wire logic load_ok,
  input wire logic page_i,
  input wire logic dc_usable,
  input wire logic l1_hit,
  input wire logic l2_hit,
  output logic touch_done_q,
  output logic touch_noop_q,
  output logic touch_xlat_q,
  output logic touch_l2_q,
  output logic touch_bus_rd_q,
  output logic touch_lru_q
);

  logic skip_all;
  logic soft_noop;

  // Early exit that skips translation entirely
  assign skip_all = seg_t | touch_dis;
  // Translated but still no effect on the caches
  assign soft_noop = !xlat_ok | !load_ok | page_i | !dc_usable;

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      touch_done_q <= 1'b0;
      touch_noop_q <= 1'b0;
      touch_xlat_q <= 1'b0;
      touch_l2_q <= 1'b0;
      touch_bus_rd_q <= 1'b0;
      touch_lru_q <= 1'b0;
    end
    else
    begin
      touch_done_q <= touch_vld;
      touch_noop_q <= touch_vld & (skip_all | soft_noop);
      touch_xlat_q <= touch_vld & !skip_all;
      touch_l2_q <= touch_vld & !skip_all & !soft_noop & !l1_hit;
      touch_bus_rd_q <= touch_vld & !skip_all & !soft_noop & !l1_hit &
        !l2_hit;
      touch_lru_q <= touch_vld & !skip_all & !soft_noop;
    end
  end

  skip_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    touch_vld && skip_all |=> !touch_xlat_q && touch_noop_q)
    else $error("skipped touch still translated");

  noop_nofill_a: assert property (@(posedge pclk) disable iff (!presetn)
    touch_vld && soft_noop |=> !touch_bus_rd_q && !touch_lru_q)
    else $error("no-op touch caused a fill");

endmodule : lcm_touch

// >>> lcm_ctrl.sv
/*
  Level-one cache maintenance control: configuration registers on APB,
  flash invalidation, instruction fetch routing, tag allocation gating,
  snoop invalidation, hardware flush walk and cache operation broadcast.
  Assumes presetn is the hard reset, soft_rst a synchronous soft reset,
  and all other inputs synchronous to pclk (20 MHz).
*/
// Overview of operation
// - Data flash invalidate clears all data lines, no broadcast, no write-back
// - Data flash bit self-clears next cycle while data cache is enabled
// - Data cache invalidated at power-up and hard reset, not soft reset
// - Instruction cache enable bit resets to zero
// - Disabled instruction cache ignores tags, fetches go single-beat to bus
// - Cache-inhibit output follows page attribute regardless of enable or lock
// - Locked instruction cache allocates nothing; only snoops and flash invalidate change tags
// - Locked miss is 32-byte burst, no L1 fill, L2 fill unless data-only
// - Instruction flash bit invalidates all and self-clears when enabled
// - Instruction cache invalidated at power-up and hard reset only
// - Hardware flush starts only on a 0 to 1 change of its bit
// - Walk ascends indices of way 0, then ways 1 to 7 likewise
// - Modified blocks get non-global write-with-kill; all lines end invalid
// - Flush stalls memory requests to data cache; snoops still serviced
// - Hardware clears flush bit once walk is done; sync drains writes
// - Snoop every cache operation broadcast with global attribute asserted; code drops data snoops while data cache is disabled
// - Data store, flush, invalidate broadcast when M=1; icache invalidate always
// - Cache operations to direct-store segments are no-ops
// - Touch to direct-store or with touch disabled skips translation
// - Touch no-op on bad translation, permission, inhibit, locked or disabled
// - Otherwise touch checks L1, L2, then bus read without modify intent
module lcm_ctrl
  import lcm_pkg::*;
#(
  parameter int SETS = 128,
  parameter int WAYS = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_vld,
  input wire logic fetch_tag_hit,
  input wire logic fetch_inhibit_attr,
  output logic cache_inhibit_out,
  output logic fetch_bus_vld,
  output logic fetch_burst,
  output logic fetch_l1_fill,
  output logic fetch_l2_fill,
  input wire logic i_alloc_vld,
  input wire logic [$clog2(SETS)-1:0] i_alloc_idx,
  input wire logic [$clog2(WAYS)-1:0] i_alloc_way,
  input wire logic d_alloc_vld,
  input wire logic d_alloc_mod,
  input wire logic [$clog2(SETS)-1:0] d_alloc_idx,
  input wire logic [$clog2(WAYS)-1:0] d_alloc_way,
  output logic mem_stall,
  input wire logic snp_vld,
  input wire logic global_attr_sig,
  input wire logic snp_d_hit,
  input wire logic snp_i_hit,
  input wire logic [$clog2(SETS)-1:0] snp_idx,
  input wire logic [$clog2(WAYS)-1:0] snp_way,
  output logic wwk_req,
  output logic wwk_global,
  output logic [$clog2(SETS)-1:0] wwk_idx,
  output logic [$clog2(WAYS)-1:0] wwk_way,
  input wire logic wwk_ack,
  input wire logic cop_vld,
  input wire logic [2:0] cop_kind,
  input wire logic cop_m,
  input wire logic cop_t,
  output logic cop_bcast,
  output logic cop_noop,
  input wire logic touch_xlat_ok,
  input wire logic touch_load_ok,
  input wire logic touch_page_i,
  input wire logic touch_l1_hit,
  input wire logic touch_l2_hit,
  output logic touch_done,
  output logic touch_noop,
  output logic touch_xlat,
  output logic touch_l2,
  output logic touch_bus_rd,
  output logic touch_lru
);

  localparam int IW = $clog2(SETS);
  localparam int WW = $clog2(WAYS);
  localparam int NL = SETS * WAYS;

  // Flush walk order is fixed to eight ways
  if (WAYS != 8)
  begin : g_ways_chk
    $error("flush walk is defined for eight ways");
  end

  logic ice_q, icache_lock_bit_q, dce_q, dlock_q, tdis_q, l2_data_only_mode_q;
  logic icache_flash_inv_bit_q, dcache_flash_inv_bit_q, hwf_q, hwf_prev_q;
  logic [NL-1:0] dval_q, dmod_q, ival_q;
  logic [31:0] prdata_q;
  lcm_flush_state_type fl_q;
  logic wr_cfg, wr_mss, rd_setup, mapped;
  logic fl_start, fl_step, fl_last, fl_done;
  logic [IW-1:0] fl_idx;
  logic [WW-1:0] fl_way;
  logic [IW+WW-1:0] fl_slot, d_slot, i_slot, s_slot;
  logic i_alloc_ok, d_alloc_ok, snp_d_ok, snp_i_ok;
  logic cop_is_data;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero-wait slave; errors answer unmapped offsets
  assign mapped = (paddr == LCM_CFG_OFS) || (paddr == LCM_MSS_OFS) ||
    (paddr == LCM_STAT_OFS);
  assign pready = psel & penable;
  assign pslverr = psel & penable & !mapped;
  assign wr_cfg = psel & penable & pwrite & (paddr == LCM_CFG_OFS);
  assign wr_mss = psel & penable & pwrite & (paddr == LCM_MSS_OFS);
  assign rd_setup = psel & !penable & !pwrite;
  assign prdata = prdata_q;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= LCM_RD_RST;
    else if (rd_setup)
    begin
      prdata_q <= '0;
      if (paddr == LCM_CFG_OFS)
      begin
        prdata_q[LCM_ICE_BIT] <= ice_q;
        prdata_q[LCM_ICACHE_LOCK_BIT_BIT] <= icache_lock_bit_q;
        prdata_q[LCM_ICACHE_FLASH_INV_BIT_BIT] <= icache_flash_inv_bit_q;
        prdata_q[LCM_DCE_BIT] <= dce_q;
        prdata_q[LCM_DCACHE_FLASH_INV_BIT_BIT] <= dcache_flash_inv_bit_q;
        prdata_q[LCM_TDIS_BIT] <= tdis_q;
        prdata_q[LCM_DLOCK_BIT] <= dlock_q;
      end
      else if (paddr == LCM_MSS_OFS)
      begin
        prdata_q[LCM_HWF_BIT] <= hwf_q;
        prdata_q[LCM_L2_DATA_ONLY_MODE_BIT] <= l2_data_only_mode_q;
      end
      else if (paddr == LCM_STAT_OFS)
      begin
        prdata_q[LCM_BUSY_BIT] <= (fl_q != LCM_FL_IDLE);
        prdata_q[LCM_IDX_LSB +: IW] <= fl_idx;
        prdata_q[LCM_WAY_LSB +: WW] <= fl_way;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration bits
  // ----------------------------------------------------------------
  // Enables, locks and modes; all cleared by hard reset only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ice_q <= LCM_CTL_RST;
      icache_lock_bit_q <= LCM_CTL_RST;
      dce_q <= LCM_CTL_RST;
      dlock_q <= LCM_CTL_RST;
      tdis_q <= LCM_CTL_RST;
      l2_data_only_mode_q <= LCM_CTL_RST;
    end
    else
    begin
      if (wr_cfg)
      begin
        ice_q <= pwdata[LCM_ICE_BIT];
        icache_lock_bit_q <= pwdata[LCM_ICACHE_LOCK_BIT_BIT];
        dce_q <= pwdata[LCM_DCE_BIT];
        dlock_q <= pwdata[LCM_DLOCK_BIT];
        tdis_q <= pwdata[LCM_TDIS_BIT];
      end
      if (wr_mss)
        l2_data_only_mode_q <= pwdata[LCM_L2_DATA_ONLY_MODE_BIT];
    end
  end

  // Flash bits: write sets, hardware clears next cycle when enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dcache_flash_inv_bit_q <= LCM_CTL_RST;
      icache_flash_inv_bit_q <= LCM_CTL_RST;
    end
    else if (soft_rst)
    begin
      dcache_flash_inv_bit_q <= LCM_CTL_RST;
      icache_flash_inv_bit_q <= LCM_CTL_RST;
    end
    else
    begin
      if (wr_cfg)
        dcache_flash_inv_bit_q <= pwdata[LCM_DCACHE_FLASH_INV_BIT_BIT];
      else if (dcache_flash_inv_bit_q && dce_q)
        dcache_flash_inv_bit_q <= 1'b0;
      if (wr_cfg)
        icache_flash_inv_bit_q <= pwdata[LCM_ICACHE_FLASH_INV_BIT_BIT];
      else if (icache_flash_inv_bit_q && ice_q)
        icache_flash_inv_bit_q <= 1'b0;
    end
  end

  // Flush trigger: software write wins over the hardware clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hwf_q <= LCM_CTL_RST;
      hwf_prev_q <= LCM_CTL_RST;
    end
    else
    begin
      hwf_prev_q <= hwf_q;
      if (wr_mss)
        hwf_q <= pwdata[LCM_HWF_BIT];
      else if (fl_done || soft_rst)
        hwf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Hardware flush sequencer
  // ----------------------------------------------------------------
  assign fl_start = hwf_q & !hwf_prev_q & (fl_q == LCM_FL_IDLE);
  assign fl_slot = {fl_way, fl_idx};
  assign fl_step = ((fl_q == LCM_FL_CHECK) &&
    !(dval_q[fl_slot] && dmod_q[fl_slot])) ||
    ((fl_q == LCM_FL_WB) && wwk_ack);
  assign fl_done = fl_step & fl_last;
  assign wwk_req = (fl_q == LCM_FL_WB);
  assign wwk_global = 1'b0;
  assign wwk_idx = fl_idx;
  assign wwk_way = fl_way;
  assign mem_stall = fl_start | (fl_q != LCM_FL_IDLE);

  lcm_walk #(
    .SETS(SETS),
    .WAYS(WAYS)
  ) u_walk (
    .pclk(pclk),
    .presetn(presetn),
    .start(fl_start),
    .step(fl_step),
    .idx(fl_idx),
    .way(fl_way),
    .last(fl_last)
  );

  // Visit each slot; write back modified ones before moving on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl_q <= LCM_FL_IDLE;
    else if (soft_rst)
      fl_q <= LCM_FL_IDLE;
    else
    begin
      case (fl_q)
        LCM_FL_IDLE:
          if (fl_start)
            fl_q <= LCM_FL_CHECK;
        LCM_FL_CHECK:
          if (dval_q[fl_slot] && dmod_q[fl_slot])
            fl_q <= LCM_FL_WB;
          else if (fl_last)
            fl_q <= LCM_FL_IDLE;
        LCM_FL_WB:
          if (wwk_ack)
            fl_q <= fl_last ? LCM_FL_IDLE : LCM_FL_CHECK;
        default:
          fl_q <= LCM_FL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Tag state
  // ----------------------------------------------------------------
  assign d_slot = {d_alloc_way, d_alloc_idx};
  assign i_slot = {i_alloc_way, i_alloc_idx};
  assign s_slot = {snp_way, snp_idx};
  assign d_alloc_ok = d_alloc_vld & dce_q & !dlock_q & !mem_stall;
  assign i_alloc_ok = i_alloc_vld & ice_q & !icache_lock_bit_q;
  assign snp_d_ok = snp_vld & global_attr_sig & snp_d_hit & dce_q;
  assign snp_i_ok = snp_vld & global_attr_sig & snp_i_hit;

  // Data lines: flash drops contents without write-back; flush clears each slot as it steps past
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dval_q <= '0;
      dmod_q <= '0;
    end
    else if (dcache_flash_inv_bit_q)
    begin
      dval_q <= '0;
      dmod_q <= '0;
    end
    else
    begin
      if (d_alloc_ok)
      begin
        dval_q[d_slot] <= 1'b1;
        dmod_q[d_slot] <= d_alloc_mod;
      end
      if (fl_step)
      begin
        dval_q[fl_slot] <= 1'b0;
        dmod_q[fl_slot] <= 1'b0;
      end
      if (snp_d_ok)
      begin
        dval_q[s_slot] <= 1'b0;
        dmod_q[s_slot] <= 1'b0;
      end
    end
  end

  // Instruction lines: only snoops and flash invalidate touch a locked cache
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ival_q <= '0;
    else if (icache_flash_inv_bit_q)
      ival_q <= '0;
    else
    begin
      if (i_alloc_ok)
        ival_q[i_slot] <= 1'b1;
      if (snp_i_ok)
        ival_q[s_slot] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Instruction fetch routing
  // ----------------------------------------------------------------
  assign cache_inhibit_out = fetch_inhibit_attr;
  assign fetch_bus_vld = fetch_vld & (!ice_q | !fetch_tag_hit);
  assign fetch_burst = fetch_vld & ice_q & !fetch_tag_hit &
    !fetch_inhibit_attr;
  assign fetch_l1_fill = fetch_burst & !icache_lock_bit_q;
  assign fetch_l2_fill = fetch_burst & !l2_data_only_mode_q;

  // ----------------------------------------------------------------
  // Cache operations and touch
  // ----------------------------------------------------------------
  assign cop_is_data = (cop_kind == LCM_OP_DSTORE) ||
    (cop_kind == LCM_OP_DFLUSH) || (cop_kind == LCM_OP_DINV);
  assign cop_noop = cop_vld & cop_t;
  assign cop_bcast = cop_vld & !cop_t & ((cop_is_data & cop_m) ||
    (cop_kind == LCM_OP_IINV));

  lcm_touch u_touch (
    .pclk(pclk),
    .presetn(presetn),
    .touch_vld(cop_vld && (cop_kind == LCM_OP_TOUCH)),
    .seg_t(cop_t),
    .touch_dis(tdis_q),
    .xlat_ok(touch_xlat_ok),
    .load_ok(touch_load_ok),
    .page_i(touch_page_i),
    .dc_usable(dce_q & !dlock_q),
    .l1_hit(touch_l1_hit),
    .l2_hit(touch_l2_hit),
    .touch_done_q(touch_done),
    .touch_noop_q(touch_noop),
    .touch_xlat_q(touch_xlat),
    .touch_l2_q(touch_l2),
    .touch_bus_rd_q(touch_bus_rd),
    .touch_lru_q(touch_lru)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  dflash_wipe_a: assert property (dcache_flash_inv_bit_q && !soft_rst |=> dval_q == '0)
    else $error("data flash left a valid line");
  dflash_clear_a: assert property (
    dcache_flash_inv_bit_q && dce_q && !wr_cfg && !soft_rst |=> !dcache_flash_inv_bit_q)
    else $error("data flash bit did not self-clear");
  iflash_clear_a: assert property (
    icache_flash_inv_bit_q && ice_q && !wr_cfg && !soft_rst |=> !icache_flash_inv_bit_q && ival_q == '0)
    else $error("instruction flash did not complete");
  icache_lock_bit_noalloc_a: assert property (
    icache_lock_bit_q |=> (ival_q & ~$past(ival_q)) == '0)
    else $error("locked icache allocated a line");
  fetch_single_a: assert property (
    fetch_vld && !ice_q |-> fetch_bus_vld && !fetch_burst)
    else $error("disabled icache fetch not single-beat");
  lock_miss_a: assert property (fetch_vld && ice_q && icache_lock_bit_q &&
    !fetch_tag_hit && !fetch_inhibit_attr |->
    fetch_burst && !fetch_l1_fill && fetch_l2_fill == !l2_data_only_mode_q)
    else $error("locked miss routed wrongly");
  flush_start_a: assert property (fl_start && !soft_rst |=>
    fl_q == LCM_FL_CHECK && fl_idx == '0 && fl_way == '0)
    else $error("flush did not start at slot zero");
  flush_stall_a: assert property (fl_q != LCM_FL_IDLE |->
    mem_stall ##1 (dval_q & ~$past(dval_q)) == '0)
    else $error("requests not stalled during flush");
  flush_end_a: assert property (fl_done && !wr_mss && !soft_rst |=>
    !hwf_q && dval_q == '0 && fl_q == LCM_FL_IDLE)
    else $error("flush ended with valid lines or bit set");
  wb_hold_a: assert property (wwk_req && !wwk_ack && !soft_rst |=>
    wwk_req && $stable(wwk_idx) && $stable(wwk_way))
    else $error("write-with-kill request dropped");
  seg_noop_a: assert property (cop_vld && cop_t |->
    cop_noop && !cop_bcast)
    else $error("direct-store operation not a no-op");
  iinv_bcast_a: assert property (
    cop_vld && !cop_t && cop_kind == LCM_OP_IINV |-> cop_bcast)
    else $error("icache invalidate not broadcast");

  flush_run_c: cover property (fl_start ##[1:1000] fl_done);
  wb_seen_c: cover property (wwk_req && wwk_ack);
  dflash_c: cover property (dcache_flash_inv_bit_q && dce_q);

endmodule : lcm_ctrl

// >>> lcm_bus_model.sv
/*
  Bus-side sink for the flush walker's write-with-kill requests.
  Assumes wwk_req with index and way stands until wwk_ack is seen.
*/
module lcm_bus_model
  import lcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic wwk_req,
  input wire logic wwk_global,
  input wire logic [3:0] wwk_idx,
  input wire logic [2:0] wwk_way,
  output logic wwk_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] log_q [$];
  logic [1:0] wait_q;
  // Acknowledge after zero or three wait cycles, logging each request
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wwk_ack <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (wwk_ack)
      wwk_ack <= 1'b0;
    else if (wwk_req && wait_q == (slow ? 2'h3 : 2'h0))
    begin
      wwk_ack <= 1'b1;
      wait_q <= 2'h0;
      log_q.push_back({wwk_global, wwk_way, wwk_idx});
    end
    else if (wwk_req)
      wait_q <= wait_q + 2'h1;
endmodule : lcm_bus_model

// >>> tb_lcm_ctrl.sv
/*
  Self-checking bench for the cache maintenance control block.
  Assumes zero-wait APB and a 16-set, 8-way geometry.
*/
module tb_lcm_ctrl
  import lcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, soft_rst = 0, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, slv, slow = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic fetch_vld = 0, fetch_tag_hit = 0, fetch_inhibit_attr = 0;
  logic cache_inhibit_out, fetch_bus_vld, fetch_burst;
  logic fetch_l1_fill, fetch_l2_fill, mem_stall;
  logic i_alloc_vld = 0, d_alloc_vld = 0, d_alloc_mod = 0;
  logic [3:0] i_alloc_idx = '0, d_alloc_idx = '0, snp_idx = '0, wwk_idx;
  logic [2:0] i_alloc_way = '0, d_alloc_way = '0, snp_way = '0, wwk_way;
  logic snp_vld = 0, global_attr_sig = 0, snp_d_hit = 0, snp_i_hit = 0;
  logic wwk_req, wwk_global, wwk_ack, cop_vld = 0, cop_m = 0, cop_t = 0;
  logic [2:0] cop_kind = '0;
  logic cop_bcast, cop_noop, touch_done, touch_noop, touch_xlat;
  logic touch_xlat_ok = 0, touch_load_ok = 0, touch_page_i = 0;
  logic touch_l1_hit = 0, touch_l2_hit = 0, touch_l2, touch_bus_rd, touch_lru;
  int err_total = 0, checks_done = 0;
  // Touch rows: config, {t,xlat,load,inhibit,l1,l2}, {noop,xlat,l2,bus}
  logic [17:0] tt [10] = '{{8'h08, 6'h38, 4'h8}, {8'h28, 6'h18, 4'h8},
    {8'h08, 6'h08, 4'hc}, {8'h08, 6'h1c, 4'hc}, {8'h48, 6'h18, 4'hc},
    {8'h00, 6'h18, 4'hc}, {8'h08, 6'h1a, 4'h4}, {8'h08, 6'h19, 4'h6},
    {8'h08, 6'h18, 4'h7}, {8'h08, 6'h10, 4'hc}};

  lcm_ctrl #(.SETS(16), .WAYS(8)) uut (.*);
  lcm_bus_model bus (.pclk(pclk), .presetn(presetn), .slow(slow),
    .wwk_req(wwk_req), .wwk_global(wwk_global), .wwk_idx(wwk_idx),
    .wwk_way(wwk_way), .wwk_ack(wwk_ack));

  always #25 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic complete_run();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // One APB transfer, waiting a bounded time for pready
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 9);
    rd = prdata;
    slv = pslverr;
    if (pready !== 1'b1)
    begin
      err_total++;
      complete_run();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb

  task automatic alloc(input logic [3:0] i, input logic [2:0] w, input m);
    d_alloc_idx <= i;
    d_alloc_way <= w;
    d_alloc_mod <= m;
    d_alloc_vld <= 1;
    @(posedge pclk);
    d_alloc_vld <= 0;
    @(posedge pclk);
  endtask : alloc

  // Hardware flush, with an allocation tried while stalled
  task automatic flush(input int nwb);
    int k;
    k = 0;
    bus.log_q.delete();
    apb(1, LCM_MSS_OFS, 1);
    @(negedge pclk);
    chk("stall", mem_stall, 1);
    @(posedge pclk);
    alloc(4'h9, 3'h3, 1);
    rd = 1;
    while (rd[0] !== 1'b0)
    begin
      if (k++ > 200)
      begin
        err_total++;
        complete_run();
      end
      apb(0, LCM_STAT_OFS, 0);
    end
    chk("wb count", bus.log_q.size(), nwb);
    apb(0, LCM_MSS_OFS, 0);
    chk("flush bit", rd, 0);
  endtask : flush

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, LCM_CFG_OFS, 0);
    chk("cfg reset", rd, 0);
    apb(0, 12'h00c, 0);
    chk("unmapped", slv, 1);
    fetch_vld <= 1;
    i_alloc_vld <= 1;
    fetch_tag_hit <= 1;
    fetch_inhibit_attr <= 1;
    @(negedge pclk);
    chk("fetch off", {fetch_bus_vld, fetch_burst, cache_inhibit_out}, 5);
    @(posedge pclk);
    apb(1, LCM_CFG_OFS, 3);
    fetch_tag_hit <= 0;
    fetch_inhibit_attr <= 0;
    @(negedge pclk);
    chk("lock miss", {fetch_bus_vld, fetch_burst, fetch_l1_fill,
      fetch_l2_fill, cache_inhibit_out}, 5'h1a);
    @(posedge pclk);
    apb(1, LCM_MSS_OFS, 2);
    @(negedge pclk);
    chk("l2 data only", {fetch_burst, fetch_l1_fill, fetch_l2_fill}, 4);
    @(posedge pclk);
    fetch_inhibit_attr <= 1;
    @(negedge pclk);
    chk("inhibit", {fetch_bus_vld, fetch_burst, fetch_l1_fill,
      fetch_l2_fill, cache_inhibit_out}, 5'h11);
    @(posedge pclk);
    apb(1, LCM_MSS_OFS, 0);
    fetch_vld <= 0;
    apb(1, LCM_CFG_OFS, 32'h18);
    apb(0, LCM_CFG_OFS, 0);
    chk("dflash", rd, 32'h08);
    apb(1, LCM_CFG_OFS, 32'h10);
    apb(0, LCM_CFG_OFS, 0);
    chk("dflash off", rd, 32'h10);
    repeat (2) apb(1, LCM_CFG_OFS, 32'h05);
    apb(0, LCM_CFG_OFS, 0);
    chk("iflash", rd, 32'h01);
    apb(1, LCM_CFG_OFS, 32'h08);
    alloc(4'h3, 3'h0, 1);
    apb(1, LCM_CFG_OFS, 32'h18);
    flush(0);
    alloc(4'h5, 3'h0, 1);
    alloc(4'h2, 3'h1, 1);
    alloc(4'h4, 3'h0, 0);
    alloc(4'h7, 3'h2, 1);
    // Local snoop must be ignored, global one must invalidate
    for (int g = 0; g < 2; g++)
    begin
      snp_idx <= g ? 4'h7 : 4'h5;
      snp_way <= g ? 3'h2 : 3'h0;
      global_attr_sig <= g[0];
      {snp_d_hit, snp_i_hit} <= 2'h3;
      snp_vld <= 1;
      @(posedge pclk);
      snp_vld <= 0;
      @(posedge pclk);
    end
    soft_rst <= 1;
    @(posedge pclk);
    soft_rst <= 0;
    slow <= 1;
    @(posedge pclk);
    flush(2);
    chk("wb first", bus.log_q[0], 8'h05);
    chk("wb second", bus.log_q[1], 8'h12);
    slow <= 0;
    flush(0);
    for (int k = 0; k < 16; k++)
    begin
      cop_kind <= 3'(k[1:0]);
      cop_m <= k[2];
      cop_t <= k[3];
      cop_vld <= 1;
      @(negedge pclk);
      chk("bcast", cop_bcast, !k[3] && (k[1:0] == 3 || k[2]));
      chk("cop noop", cop_noop, k[3]);
      @(posedge pclk);
    end
    cop_vld <= 0;
    foreach (tt[r])
    begin
      apb(1, LCM_CFG_OFS, tt[r][17:10]);
      cop_kind <= LCM_OP_TOUCH;
      cop_vld <= 1;
      {cop_t, touch_xlat_ok, touch_load_ok, touch_page_i, touch_l1_hit,
        touch_l2_hit} <= tt[r][9:4];
      @(posedge pclk);
      cop_vld <= 0;
      @(negedge pclk);
      chk("touch", {touch_done, touch_noop, touch_xlat, touch_l2,
        touch_bus_rd, touch_lru},
        {1'b1, tt[r][3:0], !tt[r][3]});
      @(posedge pclk);
    end
    complete_run();
  end
endmodule : tb_lcm_ctrl
